// File: rtl/sep_slave.sv
// two-wire serial eeprom slave: addressing, page write, timed write cycle, reads
`timescale 1ns/1ps
`default_nettype none
`include "sep_map.svh"
module sep_slave
    import sep_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'h9, // arbitrary value
    parameter int WC_CYC = `SEP_T_WC_MS * 1000000 / `SEP_CLK_NS,
    parameter int LOAD_CYC = `SEP_T_LOAD_MS * 1000000 / `SEP_CLK_NS,
    parameter int DEPTH = `SEP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic busy
);
    localparam int FILT_CYC = (`SEP_FILT_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS;
    localparam int FILT_N = (FILT_CYC < 1) ? 1 : FILT_CYC;
    localparam int WC_W = $clog2(WC_CYC + 1);
    localparam int LD_W = $clog2(LOAD_CYC + 1);

    function automatic logic addr_match(input logic [7:0] b, input logic [2:0] ref_code);
        addr_match = (b[7:4] == DEV_TYPE) && (b[3:1] == ref_code);
    endfunction

    // index 1 is the clock line, index 0 the data line
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] flt;
    logic [1:0] flt_q;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic [3:0] fcnt;
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1[gi] <= 1'b1;
                    s2[gi] <= 1'b1;
                    flt_q[gi] <= 1'b1;
                end else begin
                    s1[gi] <= gi ? scl_in : sda_in;
                    s2[gi] <= s1[gi];
                    flt_q[gi] <= flt[gi];
                end
            end
            // a single stray sample never passes: the new level must be seen twice
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flt[gi] <= 1'b1;
                    fcnt <= '0;
                end else if (s2[gi] == flt[gi]) begin
                    fcnt <= '0;
                end else if (fcnt == 4'(FILT_N)) begin
                    flt[gi] <= s2[gi];
                    fcnt <= '0;
                end else begin
                    fcnt <= fcnt + 4'h1;
                end
            end
            a_pin_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
                $changed(flt[gi]) |-> $past(s2[gi]) != $past(flt[gi])
                && $past(s2[gi], 2) == $past(s2[gi]))
                else $error("filtered line moved on a single stray sample");
        end
    endgenerate

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic sda_f;
    assign sda_f = flt[0];
    assign scl_rise = flt[1] && !flt_q[1];
    assign scl_fall = !flt[1] && flt_q[1];
    assign start_c = flt[1] && flt_q[1] && flt_q[0] && !sda_f;
    assign stop_c = flt[1] && flt_q[1] && !flt_q[0] && sda_f;

    sep_state_t state;
    sep_byte_t bidx;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic rw;
    logic ack_ok;
    logic [7:0] ahi;
    logic [7:0] alo;
    logic [8:0] cnt;
    logic pend;
    logic loading;
    logic [2:0] select_code_reference_reg;
    logic [7:0] sel_store = `SEP_SEL_RESET; // power-up content of the stored code
    logic [7:0] mem_q;
    logic [7:0] mem [`SEP_MEM_WORDS];
    logic wr_valid;
    sep_wr_t wr_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    sep_wr_t fifo_out;
    logic wc_go;
    logic [WC_W-1:0] wc_cnt;
    logic [LD_W-1:0] ld_cnt;
    logic [7:0] rx_byte;
    logic rx_done;

    assign rx_byte = {sh[6:0], sda_f};
    assign rx_done = (state == SEP_RX) && scl_rise && (bitcnt == 4'h7);
    // busy answer begins at the stop that closes write data
    assign wc_go = stop_c && pend && !busy;

    // protocol engine
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SEP_IDLE;
            bidx <= SEP_B_DEV;
            sh <= 8'h00;
            bitcnt <= 4'h0;
            rw <= 1'b0;
            ack_ok <= 1'b0;
            ahi <= 8'h00;
            alo <= 8'h00;
            cnt <= 9'h000;
            pend <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0; // open drain: only ever pulls low
            wr_valid <= 1'b0;
            wr_data <= '0;
        end else begin
            wr_valid <= 1'b0;
            if (start_c) begin
                state <= SEP_RX;
                bidx <= SEP_B_DEV;
                bitcnt <= 4'h0;
                ack_ok <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state <= SEP_IDLE;
                sda_oe <= 1'b0;
                pend <= 1'b0;
            end else begin
                unique case (state)
                    SEP_IDLE, SEP_WAIT: sda_oe <= 1'b0;
                    SEP_RX: begin
                        if (scl_rise) begin
                            sh <= rx_byte;
                            bitcnt <= bitcnt + 4'h1;
                        end
                        if (rx_done) begin
                            unique case (bidx)
                                SEP_B_DEV: begin
                                    if (!addr_match(rx_byte, select_code_reference_reg)) begin
                                        state <= SEP_IDLE;
                                    end else if (busy || loading) begin
                                        state <= SEP_WAIT;
                                    end else begin
                                        rw <= rx_byte[0];
                                        state <= SEP_ACK;
                                    end
                                end
                                SEP_B_AHI: begin
                                    ahi <= rx_byte;
                                    state <= SEP_ACK;
                                end
                                SEP_B_ALO: begin
                                    alo <= rx_byte;
                                    cnt <= {ahi[0], rx_byte};
                                    state <= SEP_ACK;
                                end
                                SEP_B_DATA: begin
                                    // a full buffer refuses the byte with a high acknowledge
                                    if (fifo_in_ready) begin
                                        wr_valid <= 1'b1;
                                        wr_data.sel <= {ahi, alo[7:3], cnt[2:0]} == `SEP_SEL_ADDR;
                                        wr_data.addr <= cnt;
                                        wr_data.data <= rx_byte;
                                        cnt <= {cnt[8:3], cnt[2:0] + 3'h1};
                                        pend <= 1'b1;
                                        state <= SEP_ACK;
                                    end else begin
                                        state <= SEP_WAIT;
                                    end
                                end
                            endcase
                        end
                    end
                    SEP_ACK: begin
                        if (scl_fall) begin
                            if (!sda_oe) begin
                                sda_oe <= 1'b1;
                            end else begin
                                bitcnt <= 4'h0;
                                if (rw) begin
                                    state <= SEP_TX;
                                    sh <= mem_q;
                                    sda_oe <= !mem_q[7];
                                end else begin
                                    sda_oe <= 1'b0;
                                    state <= SEP_RX;
                                    unique case (bidx)
                                        SEP_B_DEV: bidx <= SEP_B_AHI;
                                        SEP_B_AHI: bidx <= SEP_B_ALO;
                                        SEP_B_ALO: bidx <= SEP_B_DATA;
                                        SEP_B_DATA: bidx <= SEP_B_DATA;
                                    endcase
                                end
                            end
                        end
                    end
                    SEP_TX: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h7) begin
                                sda_oe <= 1'b0;
                                state <= SEP_MACK;
                                cnt <= cnt + 9'h001;
                            end else begin
                                sh <= {sh[6:0], 1'b0};
                                sda_oe <= !sh[6];
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    SEP_MACK: begin
                        if (scl_rise) begin
                            if (sda_f) begin
                                state <= SEP_WAIT;
                            end else begin
                                ack_ok <= 1'b1;
                            end
                        end else if (scl_fall && ack_ok) begin
                            ack_ok <= 1'b0;
                            state <= SEP_TX;
                            sh <= mem_q;
                            sda_oe <= !mem_q[7];
                            bitcnt <= 4'h0;
                        end
                    end
                    default: state <= SEP_IDLE;
                endcase
            end
        end
    end

    sep_fifo #(.W($bits(sep_wr_t)), .DEPTH(DEPTH)) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .in_valid(wr_valid),
        .in_ready(fifo_in_ready),
        .in_data(wr_data),
        .out_valid(fifo_out_valid),
        .out_ready(busy),
        .out_data(fifo_out)
    );

    // timed write cycle; buffered bytes drain into the array meanwhile
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            wc_cnt <= '0;
        end else if (wc_go) begin
            busy <= 1'b1;
            wc_cnt <= WC_W'(WC_CYC - 1);
        end else if (busy && wc_cnt != '0) begin
            wc_cnt <= wc_cnt - 1'b1;
        end else if (busy && !fifo_out_valid) begin
            busy <= 1'b0;
        end
    end

    // array writes in arrival order, so a rewritten location keeps the last byte
    always_ff @(posedge core_clk) begin
        if (busy && fifo_out_valid && !fifo_out.sel) begin
            mem[fifo_out.addr] <= fifo_out.data;
        end
        mem_q <= mem[cnt];
    end

    // stored select code is nonvolatile: rst_n leaves it alone, else a new
    // code could never reach the reference at the load after the next reset
    always_ff @(posedge core_clk) begin
        if (busy && fifo_out_valid && fifo_out.sel) begin
            sel_store <= fifo_out.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loading <= 1'b1;
            ld_cnt <= LD_W'(LOAD_CYC - 1);
            select_code_reference_reg <= 3'h0;
        end else if (loading) begin
            if (ld_cnt == '0) begin
                loading <= 1'b0;
                select_code_reference_reg <= sel_store[2:0];
            end else begin
                ld_cnt <= ld_cnt - 1'b1;
            end
        end
    end

    int busy_len;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy ? busy_len + 1 : 0;
        end
    end

    a_busy_nack: assert property (@(posedge core_clk) disable iff (!rst_n)
        (busy || loading) |-> !(state == SEP_ACK && bidx == SEP_B_DEV))
        else $error("address acknowledged while busy");
    a_wc_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        wc_go |=> busy ##1 busy)
        else $error("write cycle did not start at stop");
    a_wc_length: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(busy) |-> $past(busy_len) >= WC_CYC - 1)
        else $error("write cycle too short");
    a_page_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_done && bidx == SEP_B_DATA && fifo_in_ready)
        |=> cnt[8:3] == $past(cnt[8:3]) && cnt[2:0] == $past(cnt[2:0]) + 3'h1)
        else $error("page address step wrong");
    a_read_inc: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == SEP_TX && scl_fall && bitcnt == 4'h7 && !start_c && !stop_c)
        |=> state == SEP_MACK && cnt == $past(cnt) + 9'h001 && !sda_oe)
        else $error("read counter not advanced");
    a_out_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(sda_oe) |-> $past(scl_fall))
        else $error("data driven away from falling clock");
    a_dev_reject: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_done && bidx == SEP_B_DEV && !start_c && !stop_c
        && !addr_match(rx_byte, select_code_reference_reg))
        |=> state == SEP_IDLE ##1 !sda_oe)
        else $error("foreign address not ignored");
    a_load_done: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(loading) |-> select_code_reference_reg == $past(sel_store[2:0]))
        else $error("select code not loaded");
    a_wait_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == SEP_WAIT |=> !sda_oe)
        else $error("data line driven after refusal");
endmodule
`default_nettype wire

// File: rtl/sep_map.svh
// constants for the serial eeprom slave: addresses, reset values, timing
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH

`define SEP_CLK_NS 100
`define SEP_T_WC_MS 10
`define SEP_T_LOAD_MS 10
`define SEP_FILT_NS 50
`define SEP_MEM_WORDS 512
`define SEP_SEL_ADDR 16'hff09
`define SEP_SEL_RESET 8'h00
`define SEP_FIFO_DEPTH 16

`endif

// File: rtl/sep_pkg.sv
// types shared by the serial eeprom slave files
package sep_pkg;

    typedef enum logic [2:0] {
        SEP_IDLE = 3'b000,
        SEP_RX = 3'b001,
        SEP_ACK = 3'b010,
        SEP_TX = 3'b011,
        SEP_MACK = 3'b100,
        SEP_WAIT = 3'b101
    } sep_state_t;

    typedef enum logic [1:0] {
        SEP_B_DEV = 2'b00,
        SEP_B_AHI = 2'b01,
        SEP_B_ALO = 2'b10,
        SEP_B_DATA = 2'b11
    } sep_byte_t;

    typedef struct packed {
        logic sel;
        logic [8:0] addr;
        logic [7:0] data;
    } sep_wr_t;

endpackage

// File: rtl/sep_fifo.sv
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sep_fifo #(
    parameter int W = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;

    assign in_ready = cnt != (AW+1)'(DEPTH);
    assign out_valid = cnt != '0;
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: tb/sep_mst.sv
// two-wire bus master model driving the slave's clock and data lines
`timescale 1ns/1ps
`default_nettype none
module sep_mst (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl,
    output logic m_oe
);
    // clock stands high between frames; six low cycles cover the slave's input latency
    initial scl = 1'b1;
    initial m_oe = 1'b0;
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic bit_x(input logic b, output logic r);
        cyc(2);
        m_oe <= ~b;
        cyc(4);
        scl <= 1'b1;
        @(negedge core_clk);
        r = sda;
        cyc(2);
        scl <= 1'b0;
    endtask
    task automatic start;
        cyc(2);
        m_oe <= 1'b1;
        cyc(4);
        scl <= 1'b0;
    endtask
    task automatic restart;
        cyc(2);
        m_oe <= 1'b0;
        cyc(4);
        scl <= 1'b1;
        start();
    endtask
    task automatic stop;
        cyc(2);
        m_oe <= 1'b1;
        cyc(4);
        scl <= 1'b1;
        cyc(4);
        m_oe <= 1'b0;
        cyc(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic b9,
                        output logic [7:0] q, output logic r9);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(b9, r9);
    endtask
endmodule
`default_nettype wire

// File: tb/sep_slave_tb.sv
// self-checking bench for the serial eeprom slave behind a bus master model
`timescale 1ns/1ps
`default_nettype none
module sep_slave_tb;
    localparam int WC = 200; // shortened write cycle
    localparam int LOAD = 200;
    localparam logic [3:0] TYPE = 4'h9; // arbitrary type code, the design default
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, m_oe, sda, sda_out, sda_oe, busy, ack;
    logic [2:0] sel = 3'h0;
    logic [7:0] q;
    logic [7:0] mem [0:511];
    int errors = 0;
    int checks = 0;
    // pull-up unless a side drives; the slave puts its sda_out level on the wire
    assign sda = m_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    initial forever #50 core_clk = ~core_clk;
    sep_slave #(.DEV_TYPE(TYPE), .WC_CYC(WC), .LOAD_CYC(LOAD), .DEPTH(16)) sep_slave_i (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .busy(busy));
    sep_mst sep_mst_i (.core_clk(core_clk), .sda(sda), .scl(scl), .m_oe(m_oe));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic final_report;
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask
    task automatic send(input logic [7:0] d, input logic exp);
        sep_mst_i.xfer(d, 1'b1, q, ack);
        chk_bit(ack, exp);
    endtask
    task automatic probe(input logic [2:0] s, input logic exp);
        sep_mst_i.start();
        send({TYPE, s, 1'b0}, exp);
        sep_mst_i.stop();
    endtask
    task automatic set_addr(input logic [15:0] a);
        sep_mst_i.start();
        send({TYPE, sel, 1'b0}, 1'b0);
        send(a[15:8], 1'b0);
        send(a[7:0], 1'b0);
    endtask
    // the select-code location is kept out of the array model
    task automatic wr_seq(input logic [15:0] a, input int n, input logic [7:0] v0);
        logic [8:0] p;
        int t;
        p = a[8:0];
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            send(v0 + 8'(i), 1'b0);
            mem[p] = (a == 16'hff09) ? mem[p] : v0 + 8'(i);
            p[2:0] = p[2:0] + 3'h1;
        end
        sep_mst_i.stop();
        cyc(4);
        // busy is read away from the edge that moves it
        @(negedge core_clk);
        chk_bit(busy, 1'b1);
        probe(sel, 1'b1);
        for (t = 0; busy !== 1'b0 && t < WC + 100; t++)
            @(negedge core_clk);
        chk_bit(busy, 1'b0);
        if (busy !== 1'b0)
            final_report();
        probe(sel, 1'b0);
    endtask
    task automatic cur_read(input logic [8:0] p);
        sep_mst_i.start();
        send({TYPE, sel, 1'b1}, 1'b0);
        sep_mst_i.xfer(8'hff, 1'b1, q, ack);
        chk_byte(q, mem[p]);
        sep_mst_i.stop();
    endtask
    task automatic rd_seq(input logic [15:0] a, input int n);
        set_addr(a);
        sep_mst_i.restart();
        send({TYPE, sel, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            sep_mst_i.xfer(8'hff, i == n - 1, q, ack);
            chk_byte(q, mem[a[8:0] + 9'(i)]);
        end
    endtask
    task automatic t_loading;
        probe(3'h0, 1'b1);
        cyc(LOAD + 5);
    endtask
    task automatic t_refuse;
        for (int k = 0; k < 11; k++) begin
            sep_mst_i.start();
            send((k < 4) ? {TYPE ^ (4'h1 << k), sel, 1'b0} : {TYPE, sel ^ 3'(k - 3), 1'b0},
                1'b1);
            send(8'h00, 1'b1);
            sep_mst_i.stop();
        end
    endtask
    task automatic t_page;
        wr_seq(16'h00e5, 11, 8'h30);
        cur_read(9'h0e0);
        rd_seq(16'h00e0, 8);
        sep_mst_i.stop();
    endtask
    task automatic t_seq_read;
        wr_seq(16'h01fe, 2, 8'hc1);
        wr_seq(16'h0000, 3, 8'hd1);
        rd_seq(16'h01fe, 4);
        sep_mst_i.xfer(8'hff, 1'b1, q, ack);
        chk_byte(q, 8'hff);
        sep_mst_i.stop();
        cur_read(9'h002);
    endtask
    task automatic t_select;
        wr_seq(16'hff09, 1, 8'h03);
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(LOAD + 5);
        probe(3'h0, 1'b1);
        sel = 3'h3;
        probe(sel, 1'b0);
    endtask
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        t_loading();
        t_refuse();
        t_page();
        t_seq_read();
        t_select();
        final_report();
    end
endmodule
`default_nettype wire
